// ===== design/cmos_map.svh
// Register offsets, field positions and reset values for the margin offset select block.
`ifndef CMOS_MAP_SVH
`define CMOS_MAP_SVH
`define CMOS_MARGIN_CONTROL_ADDR 8'h56
`define CMOS_STEP1_HIGH_ADDR 8'h58
`define CMOS_STEP1_LOW_ADDR 8'h59
`define CMOS_STEP2_HIGH_ADDR 8'h5A
`define CMOS_STEP2_LOW_ADDR 8'h5B
`define CMOS_STEP3_HIGH_ADDR 8'h5C
`define CMOS_STEP8_LOW_ADDR 8'h67
`define CMOS_SW_HIGH_ADDR 8'h68
`define CMOS_SW_LOW_ADDR 8'h69
`define CMOS_READBACK_MSB 6
`define CMOS_READBACK_LSB 4
`define CMOS_OPTION_MSB 3
`define CMOS_OPTION_LSB 2
`define CMOS_OPTION_RESET 2'h0
`define CMOS_NOMINAL_CODE 3'h3
`define CMOS_STEP1_RESET 10'h0DE
`define CMOS_STEP2_RESET 10'h118
`define CMOS_STEP3_RESET 10'h14B
`define CMOS_NOMINAL_OFFSET_STEP_RESET 10'h186
`define CMOS_STEP5_RESET 10'h1BE
`define CMOS_STEP6_RESET 10'h1FE
`define CMOS_STEP7_RESET 10'h247
`define CMOS_STEP8_RESET 10'h29E
`define CMOS_SW_RESET 10'h000
`endif

// ===== design/cmos_margin_bank.sv
// Register bank and pin front end for crystal frequency margin offset selection.
//
// Contract
// - Bits 6 to 4 of margin control read back the synchronised level-select pin and cannot be written.
// - Readback codes 0..7 mean steps one to eight, with code 3 the nominal zero-offset step four.
// - With option 0 and the enable pin low, the level pin picks one of the eight step offsets.
// - With option 0 and the enable pin high, the step-four offset is applied for nominal loading.
// - With option 1 the level pin picks the step offset and the enable pin is ignored.
// - With option 2 the offset comes from the software offset register pair.
// - The option field sits at bits 3 to 2 of margin control and resets to 0.
// - Each step offset is 10 bits, upper two in bits 1..0 of a high byte, lower eight in the next byte.
// - Step one resets to upper bits 0 and lower byte DE, both writable.
// - Step two upper bits reset to 1 and are writable, with bits 7..2 reserved as zero.
//
// The strobed register port was chosen for this implementation.
`include "cmos_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cmos_margin_bank #(
    parameter int STEPS = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Board pins.
    input wire logic margin_enable_pin,
    input wire logic [2:0] margin_level_pin,
    // Crystal load adjustment.
    output logic [9:0] xo_load_offset
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [2:0] level_meta_r;
    logic [2:0] level_sync_r;
    logic enable_meta_r;
    logic enable_sync_r;
    logic [2:0] level_meta_nxt;
    logic [2:0] level_sync_nxt;
    logic enable_meta_nxt;
    logic enable_sync_nxt;

    // Two stages keep board pin metastability away from the mux and readback.
    always_comb begin
        level_meta_nxt = margin_level_pin;
        level_sync_nxt = level_meta_r;
        enable_meta_nxt = margin_enable_pin;
        enable_sync_nxt = enable_meta_r;
    end

    // Synchroniser flops; the enable pin idles high meaning nominal.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level_meta_r <= `CMOS_NOMINAL_CODE;
            level_sync_r <= `CMOS_NOMINAL_CODE;
            enable_meta_r <= 1'b1;
            enable_sync_r <= 1'b1;
        end else begin
            level_meta_r <= level_meta_nxt;
            level_sync_r <= level_sync_nxt;
            enable_meta_r <= enable_meta_nxt;
            enable_sync_r <= enable_sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    cmos_pkg::cmos_option_t option_r;
    cmos_pkg::cmos_option_t option_nxt;
    cmos_pkg::cmos_offset_t step_r [STEPS];
    cmos_pkg::cmos_offset_t step_nxt [STEPS];
    cmos_pkg::cmos_offset_t sw_r;
    cmos_pkg::cmos_offset_t sw_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    cmos_pkg::cmos_offset_t load_r;

    // Merges a byte write into one half of a 10-bit offset.
    function automatic cmos_pkg::cmos_offset_t merge_byte(input cmos_pkg::cmos_offset_t cur,
                                                        input logic low_half, input logic [7:0] data);
        if (low_half) begin
            merge_byte = {cur[9:8], data};
        end else begin
            merge_byte = {data[1:0], cur[7:0]};
        end
    endfunction

    // Reads one half of a 10-bit offset as a byte; reserved bits read zero.
    function automatic logic [7:0] split_byte(input cmos_pkg::cmos_offset_t cur, input logic low_half);
        split_byte = low_half ? cur[7:0] : {6'h00, cur[9:8]};
    endfunction

    // Offsets 0x58..0x67 hold step pairs; even address is the high byte.
    logic step_hit;
    logic [2:0] step_idx;
    logic [7:0] step_rel;
    always_comb begin
        step_rel = reg_addr - `CMOS_STEP1_HIGH_ADDR;
        step_hit = (reg_addr >= `CMOS_STEP1_HIGH_ADDR) && (reg_addr <= `CMOS_STEP8_LOW_ADDR);
        step_idx = step_rel[3:1];
    end

    // Next-state for writes and registered read data; unmapped reads return zero.
    always_comb begin
        option_nxt = option_r;
        sw_nxt = sw_r;
        rdata_nxt = rdata_r;
        for (int i = 0; i < STEPS; i++) begin
            step_nxt[i] = step_r[i];
        end
        if (reg_wr) begin
            if (reg_addr == `CMOS_MARGIN_CONTROL_ADDR) begin
                // Readback bits are ignored on write.
                option_nxt = cmos_pkg::cmos_option_t'(reg_wdata[`CMOS_OPTION_MSB:`CMOS_OPTION_LSB]);
            end else if (step_hit) begin
                step_nxt[step_idx] = merge_byte(step_r[step_idx], step_rel[0], reg_wdata);
            end else if (reg_addr == `CMOS_SW_HIGH_ADDR || reg_addr == `CMOS_SW_LOW_ADDR) begin
                sw_nxt = merge_byte(sw_r, reg_addr[0], reg_wdata);
            end
        end
        if (reg_rd) begin
            rdata_nxt = 8'h00;
            if (reg_addr == `CMOS_MARGIN_CONTROL_ADDR) begin
                rdata_nxt[`CMOS_READBACK_MSB:`CMOS_READBACK_LSB] = level_sync_r;
                rdata_nxt[`CMOS_OPTION_MSB:`CMOS_OPTION_LSB] = option_r;
            end else if (step_hit) begin
                rdata_nxt = split_byte(step_r[step_idx], step_rel[0]);
            end else if (reg_addr == `CMOS_SW_HIGH_ADDR || reg_addr == `CMOS_SW_LOW_ADDR) begin
                rdata_nxt = split_byte(sw_r, reg_addr[0]);
            end
        end
    end

    // Reset values stand in for the configuration-store restore.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            option_r <= cmos_pkg::cmos_option_t'(`CMOS_OPTION_RESET);
            sw_r <= `CMOS_SW_RESET;
            rdata_r <= 8'h00;
            step_r[0] <= `CMOS_STEP1_RESET;
            step_r[1] <= `CMOS_STEP2_RESET;
            step_r[2] <= `CMOS_STEP3_RESET;
            step_r[3] <= `CMOS_NOMINAL_OFFSET_STEP_RESET;
            step_r[4] <= `CMOS_STEP5_RESET;
            step_r[5] <= `CMOS_STEP6_RESET;
            step_r[6] <= `CMOS_STEP7_RESET;
            step_r[7] <= `CMOS_STEP8_RESET;
        end else begin
            option_r <= option_nxt;
            sw_r <= sw_nxt;
            rdata_r <= rdata_nxt;
            for (int i = 0; i < STEPS; i++) begin
                step_r[i] <= step_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset selection.

    cmos_sel_if sel_bus ();

    // Feed the selector from synchronised pins and stored tables.
    always_comb begin
        sel_bus.option = option_r;
        sel_bus.enable_low = !enable_sync_r;
        sel_bus.step_code = level_sync_r;
        sel_bus.sw_offset = sw_r;
        for (int i = 0; i < 8; i++) begin
            sel_bus.step_table[i] = step_r[i];
        end
    end

    cmos_offset_mux u_mux (
        .sel(sel_bus.sel)
    );

    // Registering the mux output costs a cycle but gives a glitch-free load code.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            load_r <= `CMOS_STEP1_RESET;
        end else begin
            load_r <= sel_bus.selected;
        end
    end

    assign reg_rdata = rdata_r;
    assign xo_load_offset = load_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_pin_gated_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        (option_r == cmos_pkg::CMOS_OPT_PIN_GATED && !enable_sync_r) |=> load_r == $past(step_r[level_sync_r]))
        else $error("gated mode did not follow level pin");
    a_nominal_when_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        (option_r == cmos_pkg::CMOS_OPT_PIN_GATED && enable_sync_r) |=> load_r == $past(step_r[3]))
        else $error("nominal step not applied");
    a_pin_only_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        (option_r == cmos_pkg::CMOS_OPT_PIN_ONLY) |=> load_r == $past(step_r[level_sync_r]))
        else $error("pin-only mode wrong offset");
    a_software_offset: assert property (@(posedge sys_clk) disable iff (!resetn)
        (option_r == cmos_pkg::CMOS_OPT_SOFTWARE) |=> load_r == $past(sw_r))
        else $error("software offset not applied");
    a_readback_level: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `CMOS_MARGIN_CONTROL_ADDR) |=> reg_rdata[6:4] == $past(level_sync_r))
        else $error("step readback mismatch");
    a_option_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `CMOS_MARGIN_CONTROL_ADDR) |=> option_r == $past(reg_wdata[3:2]))
        else $error("option field not written");
    a_step_high_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `CMOS_STEP2_HIGH_ADDR) |=> step_r[1][9:8] == $past(reg_wdata[1:0]))
        else $error("high byte write wrong");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `CMOS_STEP2_HIGH_ADDR) |=> reg_rdata[7:2] == 6'h00)
        else $error("reserved bits not zero");

    // The top bit and the low pair of margin control are reserved and must read zero.
    a_control_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `CMOS_MARGIN_CONTROL_ADDR) |=> (reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0))
        else $error("control reserved bits not zero");

    // A write to margin control must never disturb the software offset.
    a_control_write_only: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `CMOS_MARGIN_CONTROL_ADDR) |=> sw_r == $past(sw_r))
        else $error("control write leaked into offsets");

    // The low byte of step one reads back exactly what is stored.
    a_low_byte_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `CMOS_STEP1_LOW_ADDR) |=> reg_rdata == $past(step_r[0][7:0]))
        else $error("low byte read wrong");

    // The high byte of step one reads back its upper pair with zeros above.
    a_high_byte_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `CMOS_STEP1_HIGH_ADDR) |=> reg_rdata == {6'h00, $past(step_r[0][9:8])})
        else $error("high byte read wrong");

    // A write to the step one low byte lands in the lower eight bits only.
    a_step1_low_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `CMOS_STEP1_LOW_ADDR) |=> step_r[0] == {$past(step_r[0][9:8]), $past(reg_wdata)})
        else $error("step one low write wrong");

    // A write to the software low byte lands in the software offset.
    a_sw_low_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `CMOS_SW_LOW_ADDR) |=> sw_r[7:0] == $past(reg_wdata))
        else $error("software low write wrong");

    // The undefined option code keeps the crystal at nominal loading.
    a_fallback_nominal: assert property (@(posedge sys_clk) disable iff (!resetn)
        (option_r == cmos_pkg::CMOS_OPT_UNUSED) |=> load_r == $past(step_r[`CMOS_NOMINAL_CODE]))
        else $error("undefined option not nominal");

    // Unmapped addresses read as zero, so software sees no stale data there.
    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == 8'h57) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_gated_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
        option_r == cmos_pkg::CMOS_OPT_PIN_GATED && !enable_sync_r);
    c_software_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
        option_r == cmos_pkg::CMOS_OPT_SOFTWARE);
    c_readback: cover property (@(posedge sys_clk) disable iff (!resetn)
        reg_rd && reg_addr == `CMOS_MARGIN_CONTROL_ADDR);
    c_pin_only_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
        option_r == cmos_pkg::CMOS_OPT_PIN_ONLY && enable_sync_r);
    c_fallback_mode: cover property (@(posedge sys_clk) disable iff (!resetn)
        option_r == cmos_pkg::CMOS_OPT_UNUSED);
endmodule
`default_nettype wire

// ===== design/cmos_offset_mux.sv
// Combinational selector that picks the crystal offset from option, pins and tables.
`include "cmos_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cmos_offset_mux (
    // Selection request and result.
    cmos_sel_if.sel sel
);
    // Option 0 gates on the enable pin, option 1 follows the level pin, option 2 uses software.
    always_comb begin
        unique case (sel.option)
            cmos_pkg::CMOS_OPT_PIN_GATED: begin
                sel.selected = sel.enable_low ? sel.step_table[sel.step_code]
                                              : sel.step_table[`CMOS_NOMINAL_CODE];
            end
            cmos_pkg::CMOS_OPT_PIN_ONLY: begin
                sel.selected = sel.step_table[sel.step_code];
            end
            cmos_pkg::CMOS_OPT_SOFTWARE: begin
                sel.selected = sel.sw_offset;
            end
            default: begin
                // Code 3 is undefined; fall back to nominal loading so the crystal stays centred.
                sel.selected = sel.step_table[`CMOS_NOMINAL_CODE];
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== design/cmos_pkg.sv
// Types shared by the margin offset select block.
package cmos_pkg;
    typedef enum logic [1:0] {
        CMOS_OPT_PIN_GATED = 2'h0,
        CMOS_OPT_PIN_ONLY = 2'h1,
        CMOS_OPT_SOFTWARE = 2'h2,
        CMOS_OPT_UNUSED = 2'h3
    } cmos_option_t;
    typedef logic [9:0] cmos_offset_t;
endpackage

// ===== design/cmos_sel_if.sv
// Interface carrying the offset selection request and result between the bank and the selector.
`timescale 1ns/1ps
`default_nettype none
interface cmos_sel_if;
    cmos_pkg::cmos_option_t option;
    logic enable_low;
    logic [2:0] step_code;
    cmos_pkg::cmos_offset_t step_table [8];
    cmos_pkg::cmos_offset_t sw_offset;
    cmos_pkg::cmos_offset_t selected;
    modport bank (output option, output enable_low, output step_code, output step_table, output sw_offset,
        input selected);
    modport sel (input option, input enable_low, input step_code, input step_table, input sw_offset,
        output selected);
endinterface
`default_nettype wire

// ===== verification/cmos_margin_bank_tb.sv
// Self-checking testbench for the crystal margin offset select register bank.
`include "cmos_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cmos_margin_bank_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic margin_enable_pin = 1'b1;
    logic [2:0] margin_level_pin = 3'h3;
    logic [9:0] xo_load_offset;
    logic chk = 1'b0;
    logic rd_d = 1'b0;
    logic [9:0] rdq [$];
    logic [9:0] offq [$];
    logic [9:0] steps [8];
    logic [7:0] lf = 8'h58;
    logic [7:0] b1;
    logic [7:0] hi;
    int n_errors = 0;
    int n_compared = 0;

    cmos_margin_bank #(.STEPS(8)) cmos_margin_bank_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .margin_enable_pin(margin_enable_pin),
        .margin_level_pin(margin_level_pin),
        .xo_load_offset(xo_load_offset)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock.
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Driver tasks: every strobe is set in each call, so a strobe never lingers into the next request.
    task automatic drive(input logic w, input logic r, input logic c, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        chk <= c;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdq.push_back({2'h0, e});
        drive(1'b0, 1'b1, 1'b0, a, 8'h00);
    endtask

    task automatic off(input logic [9:0] e);
        offq.push_back(e);
        drive(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    endtask

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        chk <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask

    // Four edges cover the two synchroniser flops plus the output register.
    task automatic pins(input logic en, input logic [2:0] lvl);
        margin_enable_pin <= en;
        margin_level_pin <= lvl;
        idle(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: read data stand one cycle after the strobe; offset probes compare the settled output.
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d) check("reg_rdata", {2'h0, reg_rdata}, rdq.pop_front());
        if (chk) check("xo_load_offset", xo_load_offset, offq.pop_front());
    end

    // Watchdog: the sequence needs under two hundred cycles, so this limit only trips on a hang.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        steps = '{`CMOS_STEP1_RESET, `CMOS_STEP2_RESET, `CMOS_STEP3_RESET, `CMOS_NOMINAL_OFFSET_STEP_RESET,
            `CMOS_STEP5_RESET, `CMOS_STEP6_RESET, `CMOS_STEP7_RESET, `CMOS_STEP8_RESET};
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        idle(4);
        // Reset values, back to back, with an unmapped address among them.
        rd(`CMOS_MARGIN_CONTROL_ADDR, 8'h30);
        rd(8'h58, 8'h00);
        rd(8'h59, 8'hDE);
        rd(8'h5A, 8'h01);
        rd(8'h57, 8'h00);
        off(`CMOS_NOMINAL_OFFSET_STEP_RESET);
        // Only the option field takes a write; option 3 falls back to nominal.
        wr(8'h56, 8'hFF);
        rd(8'h56, 8'h3C);
        idle(3);
        off(`CMOS_NOMINAL_OFFSET_STEP_RESET);
        // Sweep every level code in option 0 (enable low) and option 1 (enable high, ignored).
        for (int opt = 0; opt < 2; opt++) begin
            wr(8'h56, {4'h0, opt[1:0], 2'h0});
            for (int k = 0; k < 8; k++) begin
                pins(opt[0], k[2:0]);
                off(steps[k]);
                rd(8'h56, {1'b0, k[2:0], opt[1:0], 2'h0});
            end
        end
        // Option 0 with enable high gives nominal loading whatever the level.
        wr(8'h56, 8'h00);
        pins(1'b1, 3'h6);
        off(`CMOS_NOMINAL_OFFSET_STEP_RESET);
        // Random step one and two offsets, reserved high bits written with random values.
        for (int i = 0; i < 2; i++) begin
            hi = 8'h58 + 8'(2 * i);
            lf = lfsr_next(lf);
            b1 = lf;
            lf = lfsr_next(lf);
            wr(hi, b1);
            wr(hi + 8'h01, lf);
            rd(hi, {6'h00, b1[1:0]});
            rd(hi + 8'h01, lf);
            pins(1'b0, i[2:0]);
            off({b1[1:0], lf});
        end
        wr(8'h57, 8'hA5);
        rd(8'h57, 8'h00);
        rd(8'h56, 8'h10);
        // Software offset ignores both pins.
        lf = lfsr_next(lf);
        b1 = lf;
        lf = lfsr_next(lf);
        wr(8'h68, b1);
        wr(8'h69, lf);
        wr(8'h56, 8'h08);
        pins(b1[7], b1[6:4]);
        off({b1[1:0], lf});
        pins(~b1[7], ~b1[6:4]);
        off({b1[1:0], lf});
        // A second reset in mid-run restores the table and the option.
        resetn <= 1'b0;
        idle(2);
        off(`CMOS_STEP1_RESET);
        resetn <= 1'b1;
        pins(1'b1, 3'h3);
        rd(8'h56, 8'h30);
        rd(8'h59, 8'hDE);
        off(`CMOS_NOMINAL_OFFSET_STEP_RESET);
        idle(4);
        stop_test();
    end
endmodule
`default_nettype wire
